/* hw/vpcr_regs.sv */
// register bank steering the first-stage oscillator pll and its output buffer
//
// What this block does
// - feedback select 0 uses first divider only, 1 uses both; resets 0
// - bypass bit 0 keeps first-stage pll on while force bit is 0, 1 disables and bypasses it
// - tuning polarity 0 positive, 1 negative; resets 0
// - force bit 1 drives control pin to half supply, unlocking the pll
// - first pump current is 50 uA times code plus one
// - first pump code resets to 11000, i.e. 1.25 mA
// - output power bit 0 powers buffered output down, 1 up; resets 0
// - output format 0 lvds, 1 lvpecl; resets 0
// - offset enable applies the five-bit phase offset code, else none
// - second pump current is 400 uA times code plus one, reset 10 mA
`timescale 1ns/1ps
module vpcr_regs
   import vpcr_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output vpcr_ctrl_type ctrl,
   output vpcr_drive_type drive
);

   if (ADDR_W < 5)
   begin : g_bad_addr
      $error("vpcr_regs: ADDR_W must reach offset output_amplitude_synth_pump");
   end

   // both pump stages share this scaling; result fits 14 bits (max 12800)
   function automatic logic [VPCR_UA_W-1:0] pump_ua(
      input logic [VPCR_CODE_W-1:0] code,
      input logic [VPCR_UA_W-1:0] step
   );
      logic [VPCR_UA_W-1:0] count;
      count = VPCR_UA_W'({1'b0, code}) + 14'h0001;
      return VPCR_UA_W'(step * count);
   endfunction

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return a == ADDR_W'(ofs);
   endfunction

   // one decode serves the reset image and the running image, so the two cannot drift
   function automatic vpcr_ctrl_type decode_fields(
      input logic [7:0] fb,
      input logic [7:0] byp,
      input logic [7:0] pp,
      input logic [7:0] oo,
      input logic [7:0] ap
   );
      vpcr_ctrl_type c;
      c.feedback_path_select = fb[VPCR_FB_SEL_BIT];
      // divider msb and amplitude are only stored; their users sit outside this bank
      c.second_feedback_divider_msb = fb[VPCR_FB_MSB_BIT];
      c.first_stage_bypass = byp[VPCR_BYPASS_BIT];
      c.tuning_polarity = pp[VPCR_POL_BIT];
      c.force_control_voltage = pp[VPCR_FORCE_BIT];
      c.first_stage_pump_code = pp[VPCR_CODE_LSB +: VPCR_CODE_W];
      c.osc_output_power_on = oo[VPCR_PWR_BIT];
      c.osc_output_format = oo[VPCR_FMT_BIT];
      c.phase_offset_enable = oo[VPCR_OFSEN_BIT];
      c.phase_offset_code = oo[VPCR_CODE_LSB +: VPCR_CODE_W];
      c.osc_output_amplitude = ap[VPCR_AMP_LSB +: 2];
      c.second_stage_pump_code = ap[VPCR_CODE_LSB +: VPCR_CODE_W];
      return c;
   endfunction

   function automatic vpcr_drive_type drive_of(input vpcr_ctrl_type c);
      vpcr_drive_type d;
      d.first_stage_pump_ua =
         pump_ua(c.first_stage_pump_code, VPCR_FIRST_STEP_UA);
      d.second_stage_pump_ua =
         pump_ua(c.second_stage_pump_code, VPCR_SECOND_STEP_UA);
      d.applied_phase_offset =
         c.phase_offset_enable ? c.phase_offset_code : '0;
      // forcing mid supply holds the loop open, so the pll cannot lock meanwhile
      d.control_pin_mid_supply = c.force_control_voltage;
      d.first_stage_active = !c.first_stage_bypass
         && !c.force_control_voltage;
      return d;
   endfunction

   logic [7:0] feedback_reg, feedback_next;
   logic [7:0] bypass_reg, bypass_next;
   logic [7:0] polpump_reg, polpump_next;
   logic [7:0] outofs_reg, outofs_next;
   logic [7:0] amppump_reg, amppump_next;
   logic [7:0] rdata_reg, rdata_next;
   vpcr_ctrl_type ctrl_reg, ctrl_next;
   vpcr_drive_type drive_reg, drive_next;

   // register select indices for the one-hot decode below
   localparam int SEL_FB = 0;
   localparam int SEL_BYP = 1;
   localparam int SEL_PP = 2;
   localparam int SEL_OO = 3;
   localparam int SEL_AP = 4;
   localparam int SEL_N = 5;

   // one decode of the offset serves both the write and the read path
   logic [SEL_N-1:0] sel;

   always_comb
   begin
      sel[SEL_FB] = addr_is(reg_addr, VPCR_FEEDBACK_OFS);
      sel[SEL_BYP] = addr_is(reg_addr, VPCR_BYPASS_OFS);
      sel[SEL_PP] = addr_is(reg_addr, VPCR_POLPUMP_OFS);
      sel[SEL_OO] = addr_is(reg_addr, VPCR_OUTOFS_OFS);
      sel[SEL_AP] = addr_is(reg_addr, VPCR_AMPPUMP_OFS);
   end

   // storage group; reserved positions are masked away on write, so reads return zero
   always_comb
   begin
      feedback_next = feedback_reg;
      bypass_next = bypass_reg;
      polpump_next = polpump_reg;
      outofs_next = outofs_reg;
      amppump_next = amppump_reg;
      if (reg_wr && sel[SEL_FB])
         feedback_next = reg_wdata & VPCR_FEEDBACK_WMASK;
      if (reg_wr && sel[SEL_BYP])
         bypass_next = reg_wdata & VPCR_BYPASS_WMASK;
      if (reg_wr && sel[SEL_PP])
         polpump_next = reg_wdata & VPCR_POLPUMP_WMASK;
      if (reg_wr && sel[SEL_OO])
         outofs_next = reg_wdata & VPCR_OUTOFS_WMASK;
      if (reg_wr && sel[SEL_AP])
         amppump_next = reg_wdata & VPCR_AMPPUMP_WMASK;
   end

   // synchronous reset loads the startup image: force set, first pump code 11000 (1.25 mA)
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         feedback_reg <= VPCR_FEEDBACK_RST;
         bypass_reg <= VPCR_BYPASS_RST;
         polpump_reg <= VPCR_POLPUMP_RST;
         outofs_reg <= VPCR_OUTOFS_RST;
         amppump_reg <= VPCR_AMPPUMP_RST;
      end
      else
      begin
         feedback_reg <= feedback_next;
         bypass_reg <= bypass_next;
         polpump_reg <= polpump_next;
         outofs_reg <= outofs_next;
         amppump_reg <= amppump_next;
      end
   end

   // read group; a read in the same cycle as a write returns the old contents
   always_comb
   begin
      rdata_next = rdata_reg;
      if (reg_rd)
      begin
         // unmapped offsets fall through to zero
         rdata_next = 8'h00;
         if (sel[SEL_FB])
            rdata_next = feedback_reg;
         if (sel[SEL_BYP])
            rdata_next = bypass_reg;
         if (sel[SEL_PP])
            rdata_next = polpump_reg;
         if (sel[SEL_OO])
            rdata_next = outofs_reg;
         if (sel[SEL_AP])
            rdata_next = amppump_reg;
      end
   end

   // the last read result stands until the next read strobe
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         rdata_reg <= VPCR_RDATA_RST;
      else
         rdata_reg <= rdata_next;
   end

   // output group decodes the next words, so fields settle together with the register
   always_comb
   begin
      ctrl_next = decode_fields(feedback_next, bypass_next, polpump_next, outofs_next,
         amppump_next);
      drive_next = drive_of(ctrl_next);
   end

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         ctrl_reg <= decode_fields(VPCR_FEEDBACK_RST, VPCR_BYPASS_RST, VPCR_POLPUMP_RST,
            VPCR_OUTOFS_RST, VPCR_AMPPUMP_RST);
         drive_reg <= drive_of(decode_fields(VPCR_FEEDBACK_RST, VPCR_BYPASS_RST,
            VPCR_POLPUMP_RST, VPCR_OUTOFS_RST, VPCR_AMPPUMP_RST));
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         drive_reg <= drive_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign ctrl = ctrl_reg;
   assign drive = drive_reg;

endmodule // vpcr_regs

/* hw/vpcr_pkg.sv */
// constants and types for the oscillator pll control register bank
package vpcr_pkg;
   localparam logic [7:0] VPCR_FEEDBACK_OFS = 8'h03;
   localparam logic [7:0] VPCR_BYPASS_OFS = 8'h0A;
   localparam logic [7:0] VPCR_POLPUMP_OFS = 8'h10;
   localparam logic [7:0] VPCR_OUTOFS_OFS = 8'h11;
   localparam logic [7:0] VPCR_AMPPUMP_OFS = 8'h12;

   // writable bits per register; the rest are reserved
   localparam logic [7:0] VPCR_FEEDBACK_WMASK = 8'h81;
   localparam logic [7:0] VPCR_BYPASS_WMASK = 8'h01;
   localparam logic [7:0] VPCR_POLPUMP_WMASK = 8'hDF;
   localparam logic [7:0] VPCR_OUTOFS_WMASK = 8'hFF;
   localparam logic [7:0] VPCR_AMPPUMP_WMASK = 8'h7F;

   localparam logic [7:0] VPCR_FEEDBACK_RST = 8'h00;
   localparam logic [7:0] VPCR_BYPASS_RST = 8'h00;
   localparam logic [7:0] VPCR_POLPUMP_RST = 8'h58;
   localparam logic [7:0] VPCR_OUTOFS_RST = 8'h00;
   localparam logic [7:0] VPCR_AMPPUMP_RST = 8'h18;
   localparam logic [7:0] VPCR_RDATA_RST = 8'h00;

   localparam int VPCR_FB_SEL_BIT = 0;
   localparam int VPCR_FB_MSB_BIT = 7;
   localparam int VPCR_BYPASS_BIT = 0;
   localparam int VPCR_POL_BIT = 7;
   localparam int VPCR_FORCE_BIT = 6;
   localparam int VPCR_PWR_BIT = 7;
   localparam int VPCR_FMT_BIT = 6;
   localparam int VPCR_OFSEN_BIT = 5;
   localparam int VPCR_AMP_LSB = 5;
   localparam int VPCR_CODE_LSB = 0;
   localparam int VPCR_CODE_W = 5;

   localparam int VPCR_UA_W = 14;
   localparam logic [VPCR_UA_W-1:0] VPCR_FIRST_STEP_UA = 14'h0032;
   localparam logic [VPCR_UA_W-1:0] VPCR_SECOND_STEP_UA = 14'h0190;

   typedef struct packed {
      logic feedback_path_select;
      logic second_feedback_divider_msb;
      logic first_stage_bypass;
      logic tuning_polarity;
      logic force_control_voltage;
      logic [VPCR_CODE_W-1:0] first_stage_pump_code;
      logic osc_output_power_on;
      logic osc_output_format;
      logic phase_offset_enable;
      logic [VPCR_CODE_W-1:0] phase_offset_code;
      logic [1:0] osc_output_amplitude;
      logic [VPCR_CODE_W-1:0] second_stage_pump_code;
   } vpcr_ctrl_type;

   typedef struct packed {
      logic [VPCR_UA_W-1:0] first_stage_pump_ua;
      logic [VPCR_UA_W-1:0] second_stage_pump_ua;
      logic [VPCR_CODE_W-1:0] applied_phase_offset;
      logic control_pin_mid_supply;
      logic first_stage_active;
   } vpcr_drive_type;
endpackage

/* test/vpcr_monitor.sv */
// assertion checker for the pll control register bank
`timescale 1ns/1ps
module vpcr_monitor
   import vpcr_pkg::*;
#(parameter int ADDR_W = 8)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire vpcr_ctrl_type ctrl,
   input wire vpcr_drive_type drive
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence pol_wr_s;
      reg_wr && reg_addr == VPCR_POLPUMP_OFS;
   endsequence
   pump_one_a: assert property (
      drive.first_stage_pump_ua == VPCR_FIRST_STEP_UA * (ctrl.first_stage_pump_code + 14'h1))
      else $error("first pump current off");
   pump_two_a: assert property (
      drive.second_stage_pump_ua == VPCR_SECOND_STEP_UA * (ctrl.second_stage_pump_code + 14'h1))
      else $error("second pump current off");
   mid_pin_a: assert property (drive.control_pin_mid_supply == ctrl.force_control_voltage)
      else $error("mid supply not following force");
   stage_on_a: assert property (
      drive.first_stage_active == (!ctrl.first_stage_bypass && !ctrl.force_control_voltage))
      else $error("first stage activity wrong");
   offset_a: assert property (
      drive.applied_phase_offset == (ctrl.phase_offset_enable ? ctrl.phase_offset_code : 5'h00))
      else $error("phase offset wrong");
   reset_vals_a: assert property ($rose(nrst) |-> ctrl.force_control_voltage
      && ctrl.first_stage_pump_code == 5'h18) else $error("reset values wrong");
   pol_write_a: assert property (pol_wr_s |=> ctrl.tuning_polarity == $past(reg_wdata[7])
      && ctrl.force_control_voltage == $past(reg_wdata[6])) else $error("polarity write lost");
   rsvd_read_a: assert property (reg_rd && reg_addr == VPCR_BYPASS_OFS
      |=> reg_rdata[7:1] == 7'h00) else $error("reserved bits read nonzero");
endmodule // vpcr_monitor

/* test/vpcr_host.sv */
// behavioural host driving the register port at falling edges
`timescale 1ns/1ps
module vpcr_host
(
   input wire logic mclk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // strobe held across exactly one rising edge, which takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule // vpcr_host

/* test/vpcr_regs_test.sv */
// self-checking bench for the pll control register bank
`timescale 1ns/1ps
module vpcr_regs_test;
   import vpcr_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic reg_wr, reg_rd;
   vpcr_ctrl_type ctrl;
   vpcr_drive_type drive;
   int bad_count = 0;
   int checks = 0;
   always #5 mclk = ~mclk;
   vpcr_regs #(.ADDR_W(8)) dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ctrl(ctrl), .drive(drive));
   vpcr_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, rd_val);
      chk({8'h00, rd_val}, {8'h00, exp});
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_reset;
      rd_chk(VPCR_FEEDBACK_OFS, 8'h00);
      rd_chk(VPCR_BYPASS_OFS, 8'h00);
      rd_chk(VPCR_POLPUMP_OFS, 8'h58);
      rd_chk(VPCR_OUTOFS_OFS, 8'h00);
      rd_chk(VPCR_AMPPUMP_OFS, 8'h18);
      chk({2'h0, drive.first_stage_pump_ua}, 16'h04E2);
      chk({2'h0, drive.second_stage_pump_ua}, 16'h2710);
      chk({15'h0, drive.control_pin_mid_supply}, 16'h0001);
      chk({14'h0, ctrl.force_control_voltage, drive.first_stage_active}, 16'h0002);
      $display("reset test done");
   endtask
   task automatic t_startup;
      host.wr(VPCR_POLPUMP_OFS, 8'h1F);
      chk({2'h0, drive.first_stage_pump_ua}, 16'h0640);
      chk({15'h0, drive.first_stage_active}, 16'h0001);
      chk({14'h0, ctrl.tuning_polarity, ctrl.force_control_voltage}, 16'h0000);
      host.wr(VPCR_POLPUMP_OFS, 8'hE0);
      rd_chk(VPCR_POLPUMP_OFS, 8'hC0);
      chk({14'h0, ctrl.tuning_polarity, ctrl.force_control_voltage}, 16'h0003);
      chk({2'h0, drive.first_stage_pump_ua}, 16'h0032);
      $display("startup test done");
   endtask
   task automatic t_fields;
      host.wr(VPCR_OUTOFS_OFS, 8'hE5);
      chk({8'h00, ctrl.osc_output_power_on, ctrl.osc_output_format,
         ctrl.phase_offset_enable, drive.applied_phase_offset}, 16'h00E5);
      host.wr(VPCR_OUTOFS_OFS, 8'h05);
      chk({11'h0, drive.applied_phase_offset}, 16'h0000);
      host.wr(VPCR_POLPUMP_OFS, 8'h00);
      host.wr(VPCR_BYPASS_OFS, 8'hFF);
      rd_chk(VPCR_BYPASS_OFS, 8'h01);
      chk({15'h0, ctrl.first_stage_bypass}, 16'h0001);
      chk({15'h0, drive.first_stage_active}, 16'h0000);
      host.wr(VPCR_FEEDBACK_OFS, 8'hFF);
      rd_chk(VPCR_FEEDBACK_OFS, 8'h81);
      chk({14'h0, ctrl.second_feedback_divider_msb,
         ctrl.feedback_path_select}, 16'h0003);
      host.wr(VPCR_AMPPUMP_OFS, 8'hFF);
      rd_chk(VPCR_AMPPUMP_OFS, 8'h7F);
      chk({9'h0, ctrl.osc_output_amplitude, ctrl.second_stage_pump_code}, 16'h007F);
      chk({2'h0, drive.second_stage_pump_ua}, 16'h3200);
      rd_chk(8'h04, 8'h00);
      $display("field test done");
   endtask
   initial
   begin
      repeat (20) @(negedge mclk);
      nrst = 1'b1;
      t_reset();
      t_startup();
      t_fields();
      finish_test();
   end
   initial
   begin
      #100000;
      bad_count++;
      finish_test();
   end
endmodule // vpcr_regs_test
bind vpcr_regs vpcr_monitor #(.ADDR_W(ADDR_W)) mon (.mclk(mclk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .ctrl(ctrl), .drive(drive));
